/* File: logic/npcs_pkg.sv */
// Constants and types of the programming-mode command interpreter.
// Assumes a 10 MHz system clock and a byte-wide memory macro.
package npcs_pkg;

  // System clock rate in MHz
  localparam int CLK_MHZ = 10;
  // Memory operation times in microseconds
  localparam int T_PROG_US = 2500;
  localparam int T_ERASE_US = 2000;
  // Derived cycle counts
  localparam int PROG_CYC = T_PROG_US * CLK_MHZ;
  localparam int ERASE_CYC = T_ERASE_US * CLK_MHZ;
  // Cycles after reset release before strap sampling
  localparam logic [1:0] BOOT_CYC = 2'h3;

  // Own serial slave address and the mode code
  localparam logic [6:0] SLAVE_ADDR = 7'h50;
  localparam logic [7:0] MODE_CODE = 8'h00;

  // Command codes
  localparam logic [7:0] CMD_ERASE_THEN_PROGRAM_BLOCK = 8'h01;
  localparam logic [7:0] CMD_ERASE_THEN_PROGRAM_SINGLE = 8'h02;
  localparam logic [7:0] CMD_CLEAR_BLOCK = 8'h03;
  localparam logic [7:0] CMD_CLEAR_SINGLE_LOCATION = 8'h04;
  localparam logic [7:0] CMD_FETCH_AT_OFFSET = 8'h05;
  localparam logic [7:0] CMD_CLEAR_ENTIRE_MEMORY = 8'h09;
  localparam logic [7:0] CMD_PROGRAM_BLOCK_NO_ERASE = 8'h0B;
  localparam logic [7:0] CMD_SELECT_PAGE = 8'h0C;
  localparam logic [7:0] CMD_FETCH_CURRENT_LOCATION = 8'h0D;
  localparam logic [7:0] CMD_ADVANCE_BLOCK_POINTER = 8'h0F;
  localparam logic [7:0] CMD_FETCH_STATUS_BYTE = 8'h13;

  // Location pointer layout and its value on entry
  localparam int PAGE_MSB = 15;
  localparam int PAGE_LSB = 8;
  localparam int BLOCK_MSB = 7;
  localparam int BLOCK_LSB = 5;
  localparam int OFS_MSB = 4;
  localparam logic [7:0] ENTRY_PAGE = 8'h30;
  localparam logic [2:0] ENTRY_BLOCK = 3'h3;
  localparam logic [4:0] ENTRY_OFS = 5'h00;
  localparam logic [4:0] LAST_OFS = 5'h1F;
  localparam logic [2:0] LAST_BLOCK = 3'h7;

  // Status byte bit positions
  localparam int ST_LOCKED = 0;
  localparam int ST_ERROR = 1;
  localparam int ST_MODE_SEEN = 2;

  // Operations handed to the memory macro
  typedef enum logic [2:0] {
    NVM_NOP = 3'h0,
    NVM_ERASE_SINGLE = 3'h1,
    NVM_ERASE_BLOCK = 3'h2,
    NVM_ERASE_ALL = 3'h3,
    NVM_PROG_BLOCK = 3'h4,
    NVM_ERASE_PROG_BLOCK = 3'h5,
    NVM_ERASE_PROG_SINGLE = 3'h6
  } npcs_nvm_op_e;

endpackage : npcs_pkg

/* File: logic/npcs_sync.sv */
// Two-stage synchroniser for a group of pin levels.
// Assumes the inputs are asynchronous to clk_sys.
module npcs_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Pin levels in and synchronised levels out
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] level_out
);

  logic [WIDTH-1:0] stage1; // First stage, read only by second

  // Two flops in series
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      stage1 <= '0;
      level_out <= '0;
    end else begin
      stage1 <= pin_in;
      level_out <= stage1;
    end
  end

endmodule : npcs_sync

/* File: logic/npcs_i2c_slave.sv */
// Byte-level serial slave: address match, write bytes, read bytes.
// Assumes synchronised line levels; open-drain enables high = pull low.
module npcs_i2c_slave (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Control from the interpreter
  input wire logic enable,
  input wire logic hold,
  input wire logic [7:0] tx_byte,
  // Synchronised line levels
  input wire logic scl_in,
  input wire logic sda_in,
  // Line drive enables
  output logic scl_oe,
  output logic sda_oe,
  // Received data and read progress
  output logic rx_valid,
  output logic [7:0] rx_byte,
  output logic tx_done
);

  typedef enum logic [2:0] {
    I_IDLE = 3'h0, I_ADDR = 3'h1, I_WRITE = 3'h3, I_READ = 3'h2,
    I_WAIT = 3'h6
  } npcs_i2c_e;

  npcs_i2c_e state; // Byte-level state
  logic scl_d; // Previous clock level
  logic sda_d; // Previous data level
  logic [7:0] shreg; // Shift register
  logic [3:0] bitcnt; // Bits moved in this byte
  logic ack_ph; // Slave drives acknowledge
  logic rack_ph; // Master acknowledge slot on reads
  logic addr_hit; // Address matched, ack pending
  logic rd_dir; // Direction bit of last address
  logic rise, fall, start_c, stop_c;

  assign rise = scl_in & ~scl_d;
  assign fall = ~scl_in & scl_d;
  assign start_c = scl_in & scl_d & sda_d & ~sda_in;
  assign stop_c = scl_in & scl_d & ~sda_d & sda_in;

  // Line history for edge and condition detection
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_d <= scl_in;
      sda_d <= sda_in;
    end
  end

  // Stretch in low phases outside the ack bit
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      scl_oe <= 1'b0;
    end else if (!hold) begin
      scl_oe <= 1'b0;
    end else if (!scl_in && !ack_ph) begin
      scl_oe <= 1'b1;
    end
  end

  // Byte engine
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      state <= I_IDLE;
      shreg <= 8'h00;
      bitcnt <= 4'h0;
      ack_ph <= 1'b0;
      rack_ph <= 1'b0;
      addr_hit <= 1'b0;
      rd_dir <= 1'b0;
      sda_oe <= 1'b0;
      rx_valid <= 1'b0;
      rx_byte <= 8'h00;
      tx_done <= 1'b0;
    end else begin
      rx_valid <= 1'b0;
      tx_done <= 1'b0;
      if (!enable || stop_c || start_c) begin
        // Release the line; a start expects an address
        state <= (enable && start_c) ? I_ADDR : I_IDLE;
        bitcnt <= 4'h0;
        sda_oe <= 1'b0;
        ack_ph <= 1'b0;
        rack_ph <= 1'b0;
      end else begin
        case (state)
          I_ADDR, I_WRITE: begin
            if (rise && !ack_ph && bitcnt < 4'h8) begin
              shreg <= {shreg[6:0], sda_in};
              bitcnt <= bitcnt + 4'h1;
              if (bitcnt == 4'h7 && state == I_WRITE) begin
                rx_valid <= 1'b1;
                rx_byte <= {shreg[6:0], sda_in};
              end
              if (bitcnt == 4'h7 && state == I_ADDR) begin
                addr_hit <= (shreg[6:0] == npcs_pkg::SLAVE_ADDR);
                rd_dir <= sda_in;
              end
            end else if (fall && bitcnt == 4'h8 && !ack_ph) begin
              // Acknowledge own address and every data byte
              if (state == I_WRITE || addr_hit) begin
                ack_ph <= 1'b1;
                sda_oe <= 1'b1;
              end else begin
                state <= I_WAIT;
              end
              bitcnt <= 4'h0;
            end else if (fall && ack_ph) begin
              ack_ph <= 1'b0;
              if (state == I_ADDR && rd_dir) begin
                // Read addressed: present first bit
                state <= I_READ;
                shreg <= tx_byte;
                sda_oe <= ~tx_byte[7];
              end else begin
                state <= I_WRITE;
                sda_oe <= 1'b0;
              end
            end
          end
          I_READ: begin
            if (rise && rack_ph) begin
              // Master not acknowledging ends the read
              if (sda_in) begin
                state <= I_WAIT;
                rack_ph <= 1'b0;
              end
            end else if (rise) begin
              bitcnt <= bitcnt + 4'h1;
            end else if (fall && rack_ph) begin
              rack_ph <= 1'b0;
              bitcnt <= 4'h0;
              shreg <= tx_byte;
              sda_oe <= ~tx_byte[7];
            end else if (fall && bitcnt == 4'h8) begin
              // Byte out: free data line for the master ack
              rack_ph <= 1'b1;
              sda_oe <= 1'b0;
              tx_done <= 1'b1;
            end else if (fall) begin
              shreg <= {shreg[6:0], 1'b0};
              sda_oe <= ~shreg[6];
            end
          end
          default: begin
            sda_oe <= 1'b0;
          end
        endcase
      end
    end
  end

endmodule : npcs_i2c_slave

/* File: logic/npcs_top.sv */
// Programming-mode command interpreter for on-chip memory.
// Assumes a memory macro with single-cycle read data.
// Functional notes
// - Strap high at reset release enters programming
// - Internal oscillator, memory power, serial on
// - Serial slave receiver, 7-bit addressing
// - Acknowledge own address 1010000
// - Mode code first, then commands executed
// - Command 01: erase, program 32 bytes
// - Command 02: offset then data, erase-program
// - Command 03: erase block by top bits
// - Command 04: erase one location at offset
// - Command 05: read at offset, then increment
// - Command 09: erase whole memory
// - Command 0B: program 32 bytes without erase
// - Command 0C: load page pointer
// - Command 0D: read current location, increment
// - Command 0F: block modulo 8, carry page
// - Command 13: return status byte
// - Entry pointer page 48 block 3 byte 0
// - Address: page, block, byte offset fields
// - Erase clears bits; stretch clock meanwhile
// - Stretch clock during block programming
module npcs_top #(
  parameter int PROG_CYCLES = npcs_pkg::PROG_CYC,
  parameter int ERASE_CYCLES = npcs_pkg::ERASE_CYC
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Programming strap pin
  input wire logic vpp_pin,
  // Serial clock line
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe,
  // Serial data line
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // System configuration
  output logic prog_mode,
  output logic osc_internal_sel,
  output logic nvm_power_en,
  // Memory macro
  output logic [15:0] nvm_addr,
  output logic [7:0] nvm_wdata,
  output logic nvm_load,
  output logic nvm_start,
  output logic [2:0] nvm_op,
  input wire logic [7:0] nvm_rdata,
  input wire logic nvm_locked
);

  typedef enum logic [2:0] {
    S_OFF = 3'h0,
    S_MODE = 3'h1,
    S_CMD = 3'h3,
    S_ARG = 3'h2,
    S_DATA = 3'h6,
    S_BUSY = 3'h7
  } npcs_state_e;

  npcs_state_e state; // Command state
  logic [1:0] boot_cnt; // Cycles since reset release
  logic booted; // Strap has been sampled
  logic vpp_s; // Synchronised strap
  logic scl_s; // Synchronised clock line
  logic sda_s; // Synchronised data line
  logic [7:0] cmd; // Command being executed
  logic arg_second; // Second argument byte pending
  logic [4:0] byte_cnt; // Block data byte count
  logic [7:0] page; // Page pointer
  logic [2:0] block; // Block pointer
  logic [4:0] ofs; // Byte offset pointer
  logic [31:0] busy_cnt; // Remaining wait cycles
  logic busy; // Memory operation running
  logic rd_status; // Reads return status, not memory
  logic err; // Sticky error flag
  logic rx_valid; // Byte received
  logic [7:0] rx_byte; // Received byte
  logic tx_done; // Read byte sent
  logic [7:0] tx_byte; // Byte offered to reads
  logic [7:0] status; // Status byte
  logic [31:0] next_wait; // Wait for the started operation
  logic next_start; // Start an operation this cycle
  logic [2:0] next_op; // Operation to start
  logic cmd_known; // Received byte is a command code

  // Synchronise strap and line levels
  npcs_sync #(
    .WIDTH(3)
  ) u_sync (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .pin_in({vpp_pin, scl_in, sda_in}),
    .level_out({vpp_s, scl_s, sda_s})
  );

  // Byte-level serial slave
  npcs_i2c_slave u_slave (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .enable(prog_mode),
    .hold(busy),
    .tx_byte(tx_byte),
    .scl_in(scl_s),
    .sda_in(sda_s),
    .scl_oe(scl_oe),
    .sda_oe(sda_oe),
    .rx_valid(rx_valid),
    .rx_byte(rx_byte),
    .tx_done(tx_done)
  );

  // Open-drain lines only ever pull low
  assign scl_out = 1'b0;
  assign sda_out = 1'b0;

  // Mode-dependent configuration outputs
  assign osc_internal_sel = prog_mode;
  assign nvm_power_en = prog_mode;

  // Location address from its three fields
  assign nvm_addr = {page, block, ofs};

  // Status byte
  always_comb begin
    status = 8'h00;
    status[npcs_pkg::ST_LOCKED] = nvm_locked;
    status[npcs_pkg::ST_ERROR] = err;
    status[npcs_pkg::ST_MODE_SEEN] = (state != S_MODE);
  end

  // Received byte names a known command
  assign cmd_known = rx_byte inside {
    npcs_pkg::CMD_ERASE_THEN_PROGRAM_BLOCK,
    npcs_pkg::CMD_ERASE_THEN_PROGRAM_SINGLE,
    npcs_pkg::CMD_CLEAR_BLOCK,
    npcs_pkg::CMD_CLEAR_SINGLE_LOCATION,
    npcs_pkg::CMD_FETCH_AT_OFFSET,
    npcs_pkg::CMD_CLEAR_ENTIRE_MEMORY,
    npcs_pkg::CMD_PROGRAM_BLOCK_NO_ERASE,
    npcs_pkg::CMD_SELECT_PAGE,
    npcs_pkg::CMD_FETCH_CURRENT_LOCATION,
    npcs_pkg::CMD_ADVANCE_BLOCK_POINTER,
    npcs_pkg::CMD_FETCH_STATUS_BYTE};

  // Read data source
  assign tx_byte = rd_status ? status : nvm_rdata;

  // Strap sampled after reset release
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      boot_cnt <= 2'h0;
      booted <= 1'b0;
      prog_mode <= 1'b0;
    end else if (!booted) begin
      boot_cnt <= boot_cnt + 2'h1;
      if (boot_cnt == npcs_pkg::BOOT_CYC) begin
        booted <= 1'b1;
        prog_mode <= vpp_s;
      end
    end else if (!vpp_s) begin
      prog_mode <= 1'b0;
    end
  end

  // Operation started by this byte
  always_comb begin
    next_start = 1'b0;
    next_op = npcs_pkg::NVM_NOP;
    next_wait = 32'h0000_0000;
    if (rx_valid && state == S_CMD &&
        rx_byte == npcs_pkg::CMD_CLEAR_ENTIRE_MEMORY) begin
      next_start = 1'b1;
      next_op = npcs_pkg::NVM_ERASE_ALL;
      next_wait = 32'(ERASE_CYCLES);
    end else if (rx_valid && state == S_DATA && byte_cnt == npcs_pkg::LAST_OFS) begin
      next_start = 1'b1;
      if (cmd == npcs_pkg::CMD_ERASE_THEN_PROGRAM_BLOCK) begin
        next_op = npcs_pkg::NVM_ERASE_PROG_BLOCK;
        next_wait = 32'(ERASE_CYCLES + PROG_CYCLES);
      end else begin
        next_op = npcs_pkg::NVM_PROG_BLOCK;
        next_wait = 32'(PROG_CYCLES);
      end
    end else if (rx_valid && state == S_ARG) begin
      case (cmd)
        npcs_pkg::CMD_ERASE_THEN_PROGRAM_SINGLE: begin
          next_start = arg_second;
          next_op = npcs_pkg::NVM_ERASE_PROG_SINGLE;
          next_wait = 32'(ERASE_CYCLES + PROG_CYCLES);
        end
        npcs_pkg::CMD_CLEAR_BLOCK: begin
          next_start = 1'b1;
          next_op = npcs_pkg::NVM_ERASE_BLOCK;
          next_wait = 32'(ERASE_CYCLES);
        end
        npcs_pkg::CMD_CLEAR_SINGLE_LOCATION: begin
          next_start = 1'b1;
          next_op = npcs_pkg::NVM_ERASE_SINGLE;
          next_wait = 32'(ERASE_CYCLES);
        end
        default: begin
          next_start = 1'b0;
        end
      endcase
    end
  end

  // Memory strobes and write data
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      nvm_load <= 1'b0;
      nvm_start <= 1'b0;
      nvm_op <= npcs_pkg::NVM_NOP;
      nvm_wdata <= 8'h00;
    end else begin
      nvm_load <= 1'b0;
      nvm_start <= next_start;
      if (next_start) begin
        nvm_op <= next_op;
      end
      if (rx_valid && state == S_DATA) begin
        nvm_load <= 1'b1;
        nvm_wdata <= rx_byte;
      end
      if (rx_valid && state == S_ARG && arg_second) begin
        nvm_load <= 1'b1;
        nvm_wdata <= rx_byte;
      end
    end
  end

  // Busy timer; clock held low meanwhile
  always_ff @(posedge clk_sys) begin
    if (!rst_n || !prog_mode) begin
      busy <= 1'b0;
      busy_cnt <= 32'h0000_0000;
    end else if (next_start) begin
      busy <= 1'b1;
      busy_cnt <= next_wait;
    end else if (busy) begin
      busy_cnt <= busy_cnt - 32'h0000_0001;
      if (busy_cnt == 32'h0000_0001) begin
        busy <= 1'b0;
      end
    end
  end

  // Command sequencer
  always_ff @(posedge clk_sys) begin
    if (!rst_n || !prog_mode) begin
      state <= prog_mode ? S_MODE : S_OFF;
      cmd <= 8'h00;
      arg_second <= 1'b0;
      byte_cnt <= 5'h00;
      rd_status <= 1'b0;
    end else begin
      case (state)
        S_OFF: begin
          state <= S_MODE;
        end
        S_MODE: begin
          // Wait for the mode code, once per entry
          if (rx_valid && rx_byte == npcs_pkg::MODE_CODE) begin
            state <= S_CMD;
          end
        end
        S_CMD: begin
          if (rx_valid) begin
            cmd <= rx_byte;
            arg_second <= 1'b0;
            byte_cnt <= 5'h00;
            case (rx_byte)
              npcs_pkg::CMD_ERASE_THEN_PROGRAM_BLOCK,
              npcs_pkg::CMD_PROGRAM_BLOCK_NO_ERASE: begin
                state <= S_DATA;
              end
              npcs_pkg::CMD_ERASE_THEN_PROGRAM_SINGLE,
              npcs_pkg::CMD_CLEAR_BLOCK,
              npcs_pkg::CMD_CLEAR_SINGLE_LOCATION,
              npcs_pkg::CMD_FETCH_AT_OFFSET,
              npcs_pkg::CMD_SELECT_PAGE: begin
                state <= S_ARG;
              end
              npcs_pkg::CMD_CLEAR_ENTIRE_MEMORY: begin
                state <= S_BUSY;
              end
              npcs_pkg::CMD_FETCH_CURRENT_LOCATION: begin
                rd_status <= 1'b0;
              end
              npcs_pkg::CMD_FETCH_STATUS_BYTE: begin
                rd_status <= 1'b1;
              end
              default: begin
                state <= S_CMD;
              end
            endcase
          end
        end
        S_ARG: begin
          if (rx_valid) begin
            if (cmd == npcs_pkg::CMD_ERASE_THEN_PROGRAM_SINGLE &&
                !arg_second) begin
              arg_second <= 1'b1;
            end else if (next_start) begin
              state <= S_BUSY;
            end else begin
              if (cmd == npcs_pkg::CMD_FETCH_AT_OFFSET) begin
                rd_status <= 1'b0;
              end
              state <= S_CMD;
            end
          end
        end
        S_DATA: begin
          if (rx_valid) begin
            byte_cnt <= byte_cnt + 5'h01;
            if (byte_cnt == npcs_pkg::LAST_OFS) begin
              state <= S_BUSY;
            end
          end
        end
        S_BUSY: begin
          // Back to commands once the memory is done
          if (!busy && !next_start) begin
            state <= S_CMD;
          end
        end
        default: begin
          state <= S_CMD;
        end
      endcase
    end
  end

  // Sticky error on unknown command; status read clears, set wins
  always_ff @(posedge clk_sys) begin
    if (!rst_n || !prog_mode) begin
      err <= 1'b0;
    end else if (rx_valid && state == S_CMD && !cmd_known) begin
      err <= 1'b1;
    end else if (tx_done && rd_status) begin
      err <= 1'b0;
    end
  end

  // Location pointer
  always_ff @(posedge clk_sys) begin
    if (!rst_n || !prog_mode) begin
      page <= npcs_pkg::ENTRY_PAGE;
      block <= npcs_pkg::ENTRY_BLOCK;
      ofs <= npcs_pkg::ENTRY_OFS;
    end else if (rx_valid && state == S_CMD &&
                 rx_byte == npcs_pkg::CMD_ADVANCE_BLOCK_POINTER) begin
      block <= block + 3'h1;
      if (block == npcs_pkg::LAST_BLOCK) begin
        page <= page + 8'h01;
      end
    end else if (rx_valid && state == S_DATA) begin
      ofs <= byte_cnt;
    end else if (rx_valid && state == S_ARG && !arg_second) begin
      case (cmd)
        npcs_pkg::CMD_SELECT_PAGE: begin
          page <= rx_byte;
        end
        npcs_pkg::CMD_CLEAR_BLOCK: begin
          block <= rx_byte[7:5];
        end
        default: begin
          ofs <= rx_byte[npcs_pkg::OFS_MSB:0];
        end
      endcase
    end else if (tx_done && !rd_status) begin
      // Post-increment after a memory read
      {page, block, ofs} <= {page, block, ofs} + 16'h0001;
    end
  end

endmodule : npcs_top

/* File: testbench/npcs_prog_model.sv */
// Behavioural programmer: serial master on open-drain lines.
// Assumes the bench resolves both wires with pull-ups.
module npcs_prog_model (
  // Clock
  input wire logic clk_sys,
  // Resolved lines
  input wire logic scl_w,
  input wire logic sda_w,
  // Pull-low enables
  output logic scl_oe,
  output logic sda_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  // Lines released at power-up
  initial begin
    scl_oe = 1'b0;
    sda_oe = 1'b0;
  end
  // Quarter of an 800 ns bit
  task automatic q();
    repeat (2) @(posedge clk_sys);
  endtask : q
  // Release clock, wait out any stretch
  task automatic up();
    scl_oe <= 1'b0;
    q();
    for (int i = 0; i < 400 && !scl_w; i++) @(posedge clk_sys);
  endtask : up
  // One bit; line sampled in high phase
  task automatic bit_x(input logic b, output logic s);
    sda_oe <= !b;
    q();
    up();
    s = sda_w;
    q();
    scl_oe <= 1'b1;
    q();
  endtask : bit_x
  // Start: data falls while clock high
  task automatic start();
    sda_oe <= 1'b0;
    up();
    q();
    sda_oe <= 1'b1;
    q();
    scl_oe <= 1'b1;
    q();
  endtask : start
  // Stop: data rises while clock high
  task automatic stop();
    sda_oe <= 1'b1;
    up();
    q();
    sda_oe <= 1'b0;
    q();
    q();
  endtask : stop
  // Byte out, MSB first; ack low means taken
  task automatic wr_byte(input logic [7:0] b, output logic a);
    logic s;
    for (int i = 7; i >= 0; i--) bit_x(b[i], s);
    bit_x(1'b1, a);
  endtask : wr_byte
  // Byte in, then ack or nack
  task automatic rd_byte(output logic [7:0] v, input logic nack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_x(1'b1, v[i]);
    bit_x(nack, s);
  endtask : rd_byte
endmodule : npcs_prog_model

/* File: testbench/npcs_assertions.sv */
// Checker on the interpreter's ports.
// Assumes the bench binds it to every top instance.
module npcs_assertions #(
  parameter int PROG_CYCLES = 40,
  parameter int ERASE_CYCLES = 30
) (
  // Clock, reset, strap
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic vpp_pin,
  // Serial lines
  input wire logic scl_in,
  input wire logic scl_out,
  input wire logic scl_oe,
  input wire logic sda_out,
  input wire logic sda_oe,
  // Mode and memory
  input wire logic prog_mode,
  input wire logic osc_internal_sel,
  input wire logic nvm_power_en,
  input wire logic [15:0] nvm_addr,
  input wire logic nvm_start,
  input wire logic [2:0] nvm_op
);
  // Still stretching shortly before busy ends
  localparam int HOLD_C = PROG_CYCLES - 5;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  sequence s_entry;
    $rose(prog_mode);
  endsequence
  sequence s_stretch;
    ##[1:30] scl_oe;
  endsequence
  mode_out_a: assert property (osc_internal_sel == prog_mode
    && nvm_power_en == prog_mode) else $error("mode outputs");
  entry_strap_a: assert property (s_entry |-> $past(vpp_pin, 3))
    else $error("entry without strap");
  entry_ptr_a: assert property (s_entry |-> nvm_addr == 16'h3060)
    else $error("entry pointer");
  idle_lines_a: assert property (!prog_mode |-> !scl_oe && !sda_oe)
    else $error("lines driven outside mode");
  od_low_a: assert property (!scl_out && !sda_out)
    else $error("open-drain level");
  ack_phase_a: assert property ($rose(sda_oe) |-> !scl_in)
    else $error("data changed in clock high");
  stretch_start_a: assert property (nvm_start |-> s_stretch)
    else $error("no stretch while busy");
  stretch_hold_a: assert property (nvm_start && nvm_op == 3'h4
    |-> ##HOLD_C scl_oe) else $error("stretch ended early");
endmodule : npcs_assertions

/* File: testbench/tb_nvm_programming_command_slave.sv */
// Bench: entry, pointers, writes, erases, reads, status.
// Assumes pull-ups on both serial wires and a 10 MHz clock.
module tb_nvm_programming_command_slave;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys, rst_n, vpp_pin, nvm_locked, scl_w, sda_w;
  logic scl_oe, sda_oe, m_scl, m_sda, prog_mode, osc_sel, pwr_en;
  logic nvm_load, nvm_start;
  logic [15:0] nvm_addr, last_addr;
  logic [7:0] nvm_wdata, nvm_rdata;
  logic [2:0] nvm_op, last_op;
  int fails, n_compared, n_load;
  // Wired lines with pull-ups; memory data from address
  assign scl_w = !(m_scl | scl_oe);
  assign sda_w = !(m_sda | sda_oe);
  assign nvm_rdata = nvm_addr[7:0] ^ nvm_addr[15:8];
  npcs_top #(.PROG_CYCLES(40), .ERASE_CYCLES(30)) u_dut (
    .clk_sys(clk_sys), .rst_n(rst_n), .vpp_pin(vpp_pin),
    .scl_in(scl_w), .scl_out(), .scl_oe(scl_oe), .sda_in(sda_w),
    .sda_out(), .sda_oe(sda_oe), .prog_mode(prog_mode),
    .osc_internal_sel(osc_sel), .nvm_power_en(pwr_en),
    .nvm_addr(nvm_addr), .nvm_wdata(nvm_wdata), .nvm_load(nvm_load),
    .nvm_start(nvm_start), .nvm_op(nvm_op), .nvm_rdata(nvm_rdata),
    .nvm_locked(nvm_locked));
  npcs_prog_model u_m (.clk_sys(clk_sys), .scl_w(scl_w),
    .sda_w(sda_w), .scl_oe(m_scl), .sda_oe(m_sda));
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  // Memory-side monitor
  always @(posedge clk_sys) begin
    if (nvm_load === 1'b1) n_load <= n_load + 1;
    if (nvm_start === 1'b1) begin
      last_op <= nvm_op;
      last_addr <= nvm_addr;
    end
  end
  task automatic chk(input string nm, input logic [15:0] e, g);
    n_compared++;
    if (g !== e) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic wb(input logic [7:0] b);
    logic a;
    u_m.wr_byte(b, a);
    chk("ack", 16'h0000, a);
  endtask : wb
  // Turn round for one byte, then back to writing
  task automatic rd(input logic [7:0] e);
    logic [7:0] v;
    u_m.stop();
    u_m.start();
    wb(8'hA1);
    u_m.rd_byte(v, 1'b1);
    u_m.stop();
    u_m.start();
    wb(8'hA0);
    chk("read", e, v);
  endtask : rd
  task automatic t_entry();
    for (int i = 0; i < 40 && prog_mode !== 1'b1; i++) @(posedge clk_sys);
    chk("prog_mode", 16'h0001, prog_mode);
    chk("osc_pwr", 16'h0003, {osc_sel, pwr_en});
    chk("entry addr", 16'h3060, nvm_addr);
    repeat (10) @(posedge clk_sys);
    $display("t_entry done");
  endtask : t_entry
  task automatic t_mode();
    logic a;
    u_m.start();
    u_m.wr_byte(8'hA2, a);
    chk("foreign addr", 16'h0001, a);
    u_m.stop();
    u_m.start();
    wb(8'hA0);
    wb(npcs_pkg::MODE_CODE);
    $display("t_mode done");
  endtask : t_mode
  task automatic t_ptr();
    wb(npcs_pkg::CMD_SELECT_PAGE);
    wb(8'h12);
    chk("page", 16'h0012, nvm_addr[15:8]);
    repeat (5) wb(npcs_pkg::CMD_ADVANCE_BLOCK_POINTER);
    chk("wrap", 16'h1300, nvm_addr);
    $display("t_ptr done");
  endtask : t_ptr
  task automatic t_byte();
    wb(npcs_pkg::CMD_ERASE_THEN_PROGRAM_SINGLE);
    wb(8'h05);
    wb(8'hA7);
    chk("op", 16'h0006, last_op);
    chk("addr", 16'h1305, last_addr);
    chk("wdata", 16'h00A7, nvm_wdata);
    $display("t_byte done");
  endtask : t_byte
  task automatic t_read();
    logic [15:0] e;
    e = nvm_addr;
    wb(npcs_pkg::CMD_FETCH_CURRENT_LOCATION);
    rd(e[7:0] ^ e[15:8]);
    chk("post inc", e + 16'h0001, nvm_addr);
    nvm_locked <= 1'b1;
    wb(8'h07);
    wb(npcs_pkg::CMD_FETCH_STATUS_BYTE);
    rd(8'h07);
    chk("no inc", e + 16'h0001, nvm_addr);
    wb(npcs_pkg::CMD_FETCH_AT_OFFSET);
    wb(8'h0A);
    rd(8'h19);
    chk("ofs inc", 16'h130B, nvm_addr);
    $display("t_read done");
  endtask : t_read
  task automatic t_block(input logic [7:0] cmd, input logic [2:0] op);
    int n0;
    wb(npcs_pkg::CMD_SELECT_PAGE);
    wb(8'h30);
    n0 = n_load;
    wb(cmd);
    for (int i = 0; i < 32; i++) wb(8'(i + 16'h0040));
    chk("loads", 16'h0020, 16'(n_load - n0));
    chk("op", op, last_op);
    chk("page", 16'h0030, last_addr[15:8]);
    $display("t_block done");
  endtask : t_block
  task automatic t_erase();
    wb(npcs_pkg::CMD_CLEAR_SINGLE_LOCATION);
    wb(8'h09);
    chk("op", 16'h0001, last_op);
    chk("ofs", 16'h0009, last_addr[4:0]);
    wb(npcs_pkg::CMD_CLEAR_BLOCK);
    wb(8'hA0);
    chk("op", 16'h0002, last_op);
    chk("blk", 16'h0005, last_addr[7:5]);
    wb(npcs_pkg::CMD_CLEAR_ENTIRE_MEMORY);
    chk("op", 16'h0003, last_op);
    u_m.stop();
    $display("t_erase done");
  endtask : t_erase
  task automatic stop_test();
    $display("compared %0d failed %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : stop_test
  initial begin
    rst_n = 1'b0;
    vpp_pin = 1'b1;
    nvm_locked = 1'b0;
    fails = 0;
    n_compared = 0;
    n_load = 0;
    repeat (8) @(posedge clk_sys);
    rst_n <= 1'b1;
    t_entry();
    t_mode();
    t_ptr();
    t_byte();
    t_read();
    t_block(npcs_pkg::CMD_PROGRAM_BLOCK_NO_ERASE, 3'h4);
    t_block(npcs_pkg::CMD_ERASE_THEN_PROGRAM_BLOCK, 3'h5);
    t_erase();
    stop_test();
  end
  // Watchdog over the whole run
  initial begin
    repeat (40000) @(posedge clk_sys);
    fails++;
    stop_test();
  end
endmodule : tb_nvm_programming_command_slave
bind npcs_top npcs_assertions #(.PROG_CYCLES(PROG_CYCLES),
  .ERASE_CYCLES(ERASE_CYCLES)) u_chk (.clk_sys(clk_sys), .rst_n(rst_n),
  .vpp_pin(vpp_pin), .scl_in(scl_in), .scl_out(scl_out), .scl_oe(scl_oe),
  .sda_out(sda_out), .sda_oe(sda_oe), .prog_mode(prog_mode),
  .osc_internal_sel(osc_internal_sel), .nvm_power_en(nvm_power_en),
  .nvm_addr(nvm_addr), .nvm_start(nvm_start), .nvm_op(nvm_op));
